// file: rtl/ppr_pkg.sv
// Function
// - Pump mode bits 3:2: 00 tristate, 01 source
// - Pump mode 10 sink, 11 normal, reset 11
// - Power bits 1:0: normal, async, unused, sync
// - Divider low byte bits 7:0, reset 01
// - Divider high six bits 5:0, reset 00
package ppr_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int PPR_ADDR_W = 10;
  localparam logic [9:0] PPR_OFS_CTRL = 10'h010;
  localparam logic [9:0] PPR_OFS_RDIV_LO = 10'h011;
  localparam logic [9:0] PPR_OFS_RDIV_HI = 10'h012;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int PPR_PUMP_LSB = 2;
  localparam int PPR_PUMP_W = 2;
  localparam int PPR_PWR_LSB = 0;
  localparam int PPR_PWR_W = 2;
  localparam int PPR_RLO_W = 8;
  localparam int PPR_RHI_W = 6;
  localparam int PPR_RDIV_W = 14;

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    PPR_PUMP_TRISTATE = 2'b00,
    PPR_PUMP_SOURCE = 2'b01,
    PPR_PUMP_SINK = 2'b10,
    PPR_PUMP_NORMAL = 2'b11
  } ppr_pump_mode_t;

  typedef enum logic [1:0] {
    PPR_PWR_NORMAL = 2'b00,
    PPR_PWR_ASYNC_DOWN = 2'b01,
    PPR_PWR_UNUSED = 2'b10,
    PPR_PWR_SYNC_DOWN = 2'b11
  } ppr_pwr_mode_t;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] PPR_PUMP_RST = 2'h3;
  localparam logic [1:0] PPR_PWR_RST = 2'h1;
  localparam logic [7:0] PPR_RLO_RST = 8'h01;
  localparam logic [5:0] PPR_RHI_RST = 6'h00;
  localparam logic [7:0] PPR_RDATA_IDLE = 8'h00;

endpackage

// file: rtl/ppr_ref_divider.sv
`timescale 1ns/10ps
`default_nettype none
module ppr_ref_divider
  import ppr_pkg::*;
#(
  parameter int DIV_W = PPR_RDIV_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic [DIV_W-1:0] divide_in,
  output var logic tick_out
);

  logic [DIV_W-1:0] count_reg;
  logic [DIV_W-1:0] count_next;
  logic tick_reg;
  logic tick_next;
  logic [DIV_W-1:0] last_count;

  // ****************************************************************
  // Reference divide counter
  // ****************************************************************
  // A divide value of zero behaves as one so the tick never stalls
  always_comb begin
    last_count = (divide_in == '0) ? '0 : divide_in - 1'b1;
    count_next = count_reg;
    tick_next = 1'b0;
    if (restart_in || !run_in) begin
      count_next = '0;
    end else if (count_reg >= last_count) begin
      count_next = '0;
      tick_next = 1'b1;
    end else begin
      count_next = count_reg + 1'b1;
    end
  end

  // Register stage only
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule
`default_nettype wire

// file: rtl/ppr_regs.sv
`timescale 1ns/10ps
`default_nettype none
module ppr_regs
  import ppr_pkg::*;
#(
  parameter int ADDR_W = PPR_ADDR_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Register port behind the serial control port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output var logic [7:0] reg_rdata_out,
  output var logic reg_rvalid_out,
  // Charge pump controls
  output var logic [1:0] charge_pump_mode_out,
  output var logic charge_pump_output_hiz_out,
  output var logic charge_pump_output_up_out,
  output var logic charge_pump_output_down_out,
  output var logic charge_pump_output_pfd_out,
  // Loop power controls
  output var logic [1:0] loop_power_mode_out,
  output var logic loop_enable_out,
  output var logic loop_async_down_out,
  output var logic loop_sync_down_out,
  // Reference divider
  output var logic [PPR_RDIV_W-1:0] ref_divide_out,
  output var logic ref_tick_out
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Address match, shared by write and read decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [1:0] pump_reg;
  logic [1:0] pump_next;
  logic [1:0] pwr_reg;
  logic [1:0] pwr_next;
  logic [7:0] rlo_reg;
  logic [7:0] rlo_next;
  logic [5:0] rhi_reg;
  logic [5:0] rhi_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic div_restart;

  // Writes land in their field; unmapped writes are dropped
  always_comb begin
    pump_next = pump_reg;
    pwr_next = pwr_reg;
    rlo_next = rlo_reg;
    rhi_next = rhi_reg;
    div_restart = 1'b0;
    if (reg_wr_in) begin
      if (addr_hit(reg_addr_in, PPR_OFS_CTRL)) begin
        pump_next = reg_wdata_in[PPR_PUMP_LSB +: PPR_PUMP_W];
        pwr_next = reg_wdata_in[PPR_PWR_LSB +: PPR_PWR_W];
      end
      if (addr_hit(reg_addr_in, PPR_OFS_RDIV_LO)) begin
        rlo_next = reg_wdata_in;
        div_restart = 1'b1;
      end
      if (addr_hit(reg_addr_in, PPR_OFS_RDIV_HI)) begin
        rhi_next = reg_wdata_in[PPR_RHI_W-1:0]; // Bits 7:6 dropped
        div_restart = 1'b1;
      end
    end
  end

  // Read data: zero-filled fields; unmapped reads answer zero
  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd_in;
    if (reg_rd_in) begin
      rdata_next = PPR_RDATA_IDLE;
      if (addr_hit(reg_addr_in, PPR_OFS_CTRL)) begin
        rdata_next[PPR_PUMP_LSB +: PPR_PUMP_W] = pump_reg;
        rdata_next[PPR_PWR_LSB +: PPR_PWR_W] = pwr_reg;
      end
      if (addr_hit(reg_addr_in, PPR_OFS_RDIV_LO)) begin
        rdata_next = rlo_reg;
      end
      if (addr_hit(reg_addr_in, PPR_OFS_RDIV_HI)) begin
        rdata_next = {2'b00, rhi_reg};
      end
    end
  end

  // Register stage for the bank and read port
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pump_reg <= PPR_PUMP_RST;
      pwr_reg <= PPR_PWR_RST;
      rlo_reg <= PPR_RLO_RST;
      rhi_reg <= PPR_RHI_RST;
      rdata_reg <= PPR_RDATA_IDLE;
      rvalid_reg <= 1'b0;
    end else begin
      pump_reg <= pump_next;
      pwr_reg <= pwr_next;
      rlo_reg <= rlo_next;
      rhi_reg <= rhi_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ****************************************************************
  // Charge pump decode
  // ****************************************************************
  logic hiz_reg;
  logic hiz_next;
  logic up_reg;
  logic up_next;
  logic down_reg;
  logic down_next;
  logic pfd_reg;
  logic pfd_next;

  // One-hot drive to the analog pump, one cycle after the field
  always_comb begin
    hiz_next = 1'b0;
    up_next = 1'b0;
    down_next = 1'b0;
    pfd_next = 1'b0;
    unique case (ppr_pump_mode_t'(pump_reg))
      PPR_PUMP_TRISTATE: begin
        hiz_next = 1'b1;
      end
      PPR_PUMP_SOURCE: begin
        up_next = 1'b1;
      end
      PPR_PUMP_SINK: begin
        down_next = 1'b1;
      end
      PPR_PUMP_NORMAL: begin
        pfd_next = 1'b1;
      end
    endcase
  end

  // Reset state matches the normal-pumping default
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hiz_reg <= 1'b0;
      up_reg <= 1'b0;
      down_reg <= 1'b0;
      pfd_reg <= 1'b1;
    end else begin
      hiz_reg <= hiz_next;
      up_reg <= up_next;
      down_reg <= down_next;
      pfd_reg <= pfd_next;
    end
  end

  // ****************************************************************
  // Loop power decode
  // ****************************************************************
  logic en_reg;
  logic en_next;
  logic adown_reg;
  logic adown_next;
  logic sdown_reg;
  logic sdown_next;
  logic ref_tick;

  // Sync power-down waits for a reference tick so the loop stops
  // on a divider boundary; async power-down acts at once.
  // The unused code is treated as async power-down, the safe side.
  always_comb begin
    en_next = en_reg;
    adown_next = 1'b0;
    sdown_next = 1'b0;
    unique case (ppr_pwr_mode_t'(pwr_reg))
      PPR_PWR_NORMAL: begin
        en_next = 1'b1;
      end
      PPR_PWR_ASYNC_DOWN, PPR_PWR_UNUSED: begin
        en_next = 1'b0;
        adown_next = 1'b1;
      end
      PPR_PWR_SYNC_DOWN: begin
        sdown_next = 1'b1;
        if (ref_tick || !en_reg) begin
          en_next = 1'b0;
        end
      end
    endcase
  end

  // Default is async power-down, loop disabled
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      en_reg <= 1'b0;
      adown_reg <= 1'b1;
      sdown_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      adown_reg <= adown_next;
      sdown_reg <= sdown_next;
    end
  end

  // ****************************************************************
  // Reference divider
  // ****************************************************************
  logic [PPR_RDIV_W-1:0] rdiv_reg;
  logic [PPR_RDIV_W-1:0] rdiv_next;

  // Full count: high six bits above the low byte
  always_comb begin
    rdiv_next = {rhi_reg, rlo_reg};
  end

  // Registered so the counter sees a stable word
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdiv_reg <= {PPR_RHI_RST, PPR_RLO_RST};
    end else begin
      rdiv_reg <= rdiv_next;
    end
  end

  // Counter restarts on any divider write to avoid a stale phase
  ppr_ref_divider #(
    .DIV_W(PPR_RDIV_W)
  ) u_ref_divider (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .run_in(en_reg),
    .restart_in(div_restart),
    .divide_in(rdiv_reg),
    .tick_out(ref_tick)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign charge_pump_mode_out = pump_reg;
  assign charge_pump_output_hiz_out = hiz_reg;
  assign charge_pump_output_up_out = up_reg;
  assign charge_pump_output_down_out = down_reg;
  assign charge_pump_output_pfd_out = pfd_reg;
  assign loop_power_mode_out = pwr_reg;
  assign loop_enable_out = en_reg;
  assign loop_async_down_out = adown_reg;
  assign loop_sync_down_out = sdown_reg;
  assign ref_divide_out = rdiv_reg;
  assign ref_tick_out = ref_tick;

endmodule
`default_nettype wire

// file: tb/ppr_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module ppr_regs_chk
  import ppr_pkg::*;
#(
  parameter int ADDR_W = PPR_ADDR_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic [1:0] charge_pump_mode_out,
  input wire logic charge_pump_output_hiz_out,
  input wire logic charge_pump_output_up_out,
  input wire logic charge_pump_output_down_out,
  input wire logic charge_pump_output_pfd_out,
  input wire logic [1:0] loop_power_mode_out,
  input wire logic loop_enable_out,
  input wire logic loop_async_down_out,
  input wire logic loop_sync_down_out,
  input wire logic [PPR_RDIV_W-1:0] ref_divide_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // ****************
  // Register port
  // ****************
  // Read of a control byte is taken on the strobe edge
  sequence s_rd_ctrl;
    reg_rd_in && reg_addr_in == PPR_OFS_CTRL;
  endsequence
  sequence s_rd_hi;
    reg_rd_in && reg_addr_in == PPR_OFS_RDIV_HI;
  endsequence
  a_ctrl_read_back: assert property (
    s_rd_ctrl |=> reg_rvalid_out && reg_rdata_out ==
      {4'h0, $past(charge_pump_mode_out), $past(loop_power_mode_out)})
    else $error("control read back wrong");
  a_ctrl_write: assert property (
    reg_wr_in && reg_addr_in == PPR_OFS_CTRL |=>
      {charge_pump_mode_out, loop_power_mode_out} == $past(reg_wdata_in[3:0]))
    else $error("control write not stored");
  a_rhi_read_zero: assert property (
    s_rd_hi |=> reg_rvalid_out && reg_rdata_out[7:6] == 2'h0)
    else $error("divider high top bits not zero");
  a_rlo_write: assert property (
    reg_wr_in && reg_addr_in == PPR_OFS_RDIV_LO |-> ##2
      ref_divide_out[7:0] == $past(reg_wdata_in, 2))
    else $error("divider low byte not applied");
  a_rhi_write: assert property (
    reg_wr_in && reg_addr_in == PPR_OFS_RDIV_HI |-> ##2
      ref_divide_out[13:8] == $past(reg_wdata_in[5:0], 2))
    else $error("divider high bits not applied");
  // ****************
  // Decoded controls
  // ****************
  // One-hot pump controls follow the stored code a cycle later
  a_pump_decode: assert property (
    1'b1 |=> {charge_pump_output_hiz_out, charge_pump_output_up_out,
      charge_pump_output_down_out, charge_pump_output_pfd_out} ==
      (4'h8 >> $past(charge_pump_mode_out)))
    else $error("pump decode wrong");
  a_power_run: assert property (
    loop_power_mode_out == 2'h0 |=> loop_enable_out && !loop_async_down_out)
    else $error("loop not running in normal mode");
  a_power_async: assert property (
    loop_power_mode_out inside {2'h1, 2'h2} |=> !loop_enable_out && loop_async_down_out)
    else $error("async power down missing");
  a_power_sync: assert property (
    loop_power_mode_out == 2'h3 |=> loop_sync_down_out && !loop_async_down_out)
    else $error("sync power down missing");
endmodule
bind ppr_regs ppr_regs_chk #(.ADDR_W(ADDR_W)) i_chk (.clk_sys_in, .rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out,
  .charge_pump_mode_out, .charge_pump_output_hiz_out, .charge_pump_output_up_out,
  .charge_pump_output_down_out, .charge_pump_output_pfd_out, .loop_power_mode_out,
  .loop_enable_out, .loop_async_down_out, .loop_sync_down_out, .ref_divide_out);
`default_nettype wire

// file: tb/ppr_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module ppr_regs_test
  import ppr_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [9:0] reg_addr_in = 10'h000;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out, d;
  logic reg_rvalid_out, charge_pump_output_hiz_out, charge_pump_output_up_out;
  logic charge_pump_output_down_out, charge_pump_output_pfd_out, ref_tick_out;
  logic loop_enable_out, loop_async_down_out, loop_sync_down_out;
  logic [1:0] charge_pump_mode_out, loop_power_mode_out;
  logic [13:0] ref_divide_out;
  // One-hot pump drive gathered as hiz, up, down, pfd
  wire logic [3:0] pump_oh = {charge_pump_output_hiz_out, charge_pump_output_up_out,
    charge_pump_output_down_out, charge_pump_output_pfd_out};
  int n_fail = 0;
  int check_count = 0;
  int n;
  always #4 clk_sys_in = ~clk_sys_in;
  ppr_regs i_dut (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .charge_pump_mode_out,
    .charge_pump_output_hiz_out, .charge_pump_output_up_out, .charge_pump_output_down_out,
    .charge_pump_output_pfd_out, .loop_power_mode_out, .loop_enable_out,
    .loop_async_down_out, .loop_sync_down_out, .ref_divide_out, .ref_tick_out);
  // ****************
  // Access tasks
  // ****************
  task automatic end_sim();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Waits land after the edge so registered outputs are settled
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  // Bounded wait for the answer; a lost answer ends the run
  task automatic rd_reg(input logic [9:0] a);
    int k;
    k = 0;
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    while (reg_rvalid_out !== 1'b1 && k < 4) begin
      cyc(1);
      k++;
    end
    if (reg_rvalid_out !== 1'b1) begin
      $display("BAD rvalid exp 1 got 0");
      n_fail++;
      end_sim();
    end
    d = reg_rdata_out;
  endtask
  task automatic wait_tick();
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (ref_tick_out !== 1'b1 && n < 20);
    // A lost tick ends the run as a mismatch
    if (ref_tick_out !== 1'b1) begin
      $display("BAD tick wait exp 1 got 0");
      n_fail++;
      end_sim();
    end
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rd_reg(PPR_OFS_CTRL);
    `CHK("ctrl rst", 8'h0D, d)
    rd_reg(PPR_OFS_RDIV_LO);
    `CHK("rlo rst", 8'h01, d)
    rd_reg(PPR_OFS_RDIV_HI);
    `CHK("rhi rst", 8'h00, d)
    `CHK("div rst", 14'h0001, ref_divide_out)
    $display("reset test done");
    // Upper nibble is written as ones to prove it is dropped
    for (int m = 0; m < 4; m++) begin
      wr_reg(PPR_OFS_CTRL, {4'hF, 2'(m), 2'h1});
      cyc(2);
      `CHK("pump", 4'h8 >> m, pump_oh)
      rd_reg(PPR_OFS_CTRL);
      `CHK("ctrl rd", {4'h0, 2'(m), 2'h1}, d)
    end
    $display("pump test done");
    wr_reg(PPR_OFS_RDIV_LO, 8'hFF);
    wr_reg(PPR_OFS_RDIV_HI, 8'hFF);
    cyc(2);
    `CHK("div", 14'h3FFF, ref_divide_out)
    rd_reg(PPR_OFS_RDIV_HI);
    `CHK("rhi rd", 8'h3F, d)
    wr_reg(10'h013, 8'h00);
    rd_reg(10'h013);
    `CHK("unmapped", 8'h00, d)
    rd_reg(PPR_OFS_RDIV_LO);
    `CHK("rlo kept", 8'hFF, d)
    $display("divider test done");
    // Sync power-down is entered from async so the loop is already idle
    for (int p = 1; p < 5; p++) begin
      wr_reg(PPR_OFS_CTRL, {6'h03, 2'(p % 4)});
      cyc(2);
      `CHK("enable", p == 4, loop_enable_out)
      `CHK("async", p < 3, loop_async_down_out)
      `CHK("sync", p == 3, loop_sync_down_out)
    end
    $display("power test done");
    wr_reg(PPR_OFS_RDIV_LO, 8'h03);
    wr_reg(PPR_OFS_RDIV_HI, 8'h00);
    wait_tick();
    `CHK("first tick", 1'b1, ref_tick_out)
    wait_tick();
    `CHK("tick period", 3, n)
    // Sync power-down from a running loop: enable holds to the next tick
    wr_reg(PPR_OFS_CTRL, 8'h0F);
    cyc(1);
    `CHK("sync hold", 1'b1, loop_enable_out)
    `CHK("sync tick", 1'b1, ref_tick_out)
    cyc(1);
    `CHK("sync stop", 1'b0, loop_enable_out)
    cyc(4);
    `CHK("tick stop", 1'b0, ref_tick_out)
    $display("tick test done");
    end_sim();
  end
endmodule
`default_nettype wire
